// File: hdl/stx_input_stage.sv
/*
 * Transmit input stage: pin synchronisers, phase-align FIFO, parity check
 * with bad-character substitution, self-test progress and the fault flag.
 * Assumes all pins are asynchronous to sys_clk and sys_clk is several times
 * faster than the reference and host transmit clocks.
 */
`timescale 1ns/1ps

// ------------------------------------------------------------
// Three-flop synchroniser; a bit moves once stages two and three agree.
// ------------------------------------------------------------
module stx_sync3 #(
    parameter int W = 1
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset,
    // Asynchronous input and its settled level.
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] level_r
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    wire [W-1:0] agree = ~(s2_r ^ s3_r);

    // The first stage feeds only the second one.
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            level_r <= '0;
        end
        else
        begin
            s1_r <= async_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            level_r <= (agree & s3_r) | (~agree & level_r);
        end
    end
endmodule

// ------------------------------------------------------------
// Small FIFO with valid and ready on both sides and a flush.
// ------------------------------------------------------------
module stx_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 4
) (
    // Clock, reset and recentering flush.
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic flush,
    // Fill side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    if (DEPTH < 2 || (1 << AW) != DEPTH)
    begin : g_bad_depth
        $error("FIFO depth must be a power of two of at least two.");
    end

    assign in_ready = cnt_r != FULL;
    assign out_valid = cnt_r != '0;
    assign out_data = mem[rp_r];

    // Pointers wrap naturally because the depth is a power of two.
    always_ff @(posedge sys_clk)
    begin
        if (reset || flush)
        begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end
        else
        begin
            wp_r <= wp_r + AW'(push);
            rp_r <= rp_r + AW'(pop);
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (push)
        begin
            mem[wp_r] <= in_data;
        end
    end
endmodule

module stx_input_stage (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset,
    // Link clocks and phase reset pin.
    input wire logic reference_clock,
    input wire logic host_tx_clock,
    input wire logic tx_phase_reset_n,
    // Static configuration pins.
    input wire logic [1:0] tx_input_clock_select,
    input wire logic ref_half_rate_select,
    input wire logic [1:0] rx_output_clock_select,
    input wire logic [3:0] tx_mode_select,
    input wire logic [1:0] parity_control,
    input wire logic bist_enable,
    // Host character inputs.
    input wire logic [7:0] tx_char,
    input wire logic [1:0] tx_control_code,
    input wire logic tx_odd_parity_in,
    input wire logic special_char_select,
    // Encoder side.
    output logic enc_strobe_r,
    output logic [7:0] enc_char_r,
    output logic [1:0] enc_code_r,
    output logic [1:0] enc_kind_r,
    output logic enc_bypass_r,
    // Status.
    output logic tx_fault_flag_r,
    output logic buffer_ready_r
);
    // ------------------------------------------------------------
    // Pin synchronisers.
    // ------------------------------------------------------------
    logic [2:0] clk_lvl;
    logic [2:0] clk_prev_r;
    logic [11:0] cfg_lvl;
    logic [stx_pkg::WORD_W-1:0] word_lvl;

    stx_sync3 #(.W(3)) u_clk_sync (
        .sys_clk(sys_clk),
        .reset(reset),
        .async_in({tx_phase_reset_n, host_tx_clock, reference_clock}),
        .level_r(clk_lvl)
    );
    stx_sync3 #(.W(12)) u_cfg_sync (
        .sys_clk(sys_clk),
        .reset(reset),
        .async_in({bist_enable, parity_control, tx_mode_select, rx_output_clock_select,
                   ref_half_rate_select, tx_input_clock_select}),
        .level_r(cfg_lvl)
    );
    stx_sync3 #(.W(stx_pkg::WORD_W)) u_word_sync (
        .sys_clk(sys_clk),
        .reset(reset),
        .async_in({special_char_select, tx_odd_parity_in, tx_control_code, tx_char}),
        .level_r(word_lvl)
    );

    // ------------------------------------------------------------
    // Decoded configuration and clock edges.
    // ------------------------------------------------------------
    wire [1:0] in_sel = cfg_lvl[1:0];
    wire half_rate = cfg_lvl[2];
    wire [1:0] rx_sel = cfg_lvl[4:3];
    wire [1:0] mode_lo = cfg_lvl[6:5];
    wire [1:0] mode_hi = cfg_lvl[8:7];
    wire [1:0] par_ctl = cfg_lvl[10:9];
    wire bist_on = cfg_lvl[11];
    wire ref_rise = clk_lvl[0] && !clk_prev_r[0];
    wire ref_fall = !clk_lvl[0] && clk_prev_r[0];
    wire host_rise = clk_lvl[1] && !clk_prev_r[1];
    wire phase_rst_low = !clk_lvl[2];
    wire char_tick = ref_rise || (half_rate && ref_fall);
    wire sel_low = in_sel == stx_pkg::LVL_LOW;
    wire cap_tick = sel_low ? char_tick : host_rise;
    wire buf_active = !sel_low || half_rate;
    wire enc_on = mode_hi != stx_pkg::LVL_LOW;
    wire mode_ll = enc_on == 1'b0 && mode_lo == stx_pkg::LVL_LOW;

    always_ff @(posedge sys_clk)
    begin
        clk_prev_r <= reset ? 3'h4 : clk_lvl;
    end

    // ------------------------------------------------------------
    // Phase-align FIFO between capture and encoder.
    // ------------------------------------------------------------
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [stx_pkg::WORD_W-1:0] fifo_word;
    logic [1:0] prst_cnt_r;
    logic primed_r;
    logic fault_r;
    wire recenter = buf_active && ref_rise && phase_rst_low
        && prst_cnt_r == stx_pkg::PHASE_RST_EDGES - 2'h1;
    wire pop = char_tick && fifo_out_valid;

    // Word, code and special select all ride the selected capture edge.
    stx_fifo #(.WIDTH(stx_pkg::WORD_W), .DEPTH(stx_pkg::FIFO_DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .reset(reset),
        .flush(recenter),
        .in_valid(cap_tick),
        .in_ready(fifo_in_ready),
        .in_data(word_lvl),
        .out_valid(fifo_out_valid),
        .out_ready(char_tick),
        .out_data(fifo_word)
    );

    // ------------------------------------------------------------
    // Parity check, substitution and kind decode at the encoder.
    // ------------------------------------------------------------
    wire [7:0] w_char = fifo_word[stx_pkg::CHAR_W-1:0];
    wire [1:0] w_code = fifo_word[stx_pkg::CODE_LSB+1:stx_pkg::CODE_LSB];
    wire w_spc = fifo_word[stx_pkg::SPC_BIT];
    wire code_cov = par_ctl == stx_pkg::LVL_HIGH;
    wire par_sum = ^w_char ^ (code_cov & ^w_code) ^ fifo_word[stx_pkg::PAR_BIT];
    wire par_bad = par_ctl != stx_pkg::LVL_LOW && !par_sum;
    wire [1:0] w_kind = !enc_on ? stx_pkg::KIND_DATA
        : (w_spc && w_code == stx_pkg::KIND_DATA) ? stx_pkg::KIND_SPECIAL : w_code;
    wire sync_sent = pop && w_kind == stx_pkg::KIND_SYNC;

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            enc_strobe_r <= 1'b0;
            enc_char_r <= 8'h00;
            enc_code_r <= 2'h0;
            enc_kind_r <= 2'h0;
            enc_bypass_r <= 1'b0;
        end
        else
        begin
            enc_strobe_r <= pop;
            if (pop)
            begin
                enc_char_r <= par_bad ? stx_pkg::CHAR_C07 : w_char;
                enc_code_r <= par_bad ? stx_pkg::KIND_DATA : w_code;
                enc_kind_r <= par_bad ? stx_pkg::KIND_DATA : w_kind;
                enc_bypass_r <= !enc_on;
            end
        end
    end

    // ------------------------------------------------------------
    // Phase buffer faults and recentering; a new fault beats a clear.
    // ------------------------------------------------------------
    // No faults while the phase reset is held low: the buffer is being realigned then,
    // and an empty buffer at the flush tick would otherwise re-arm the flag it clears.
    wire overflow = buf_active && !phase_rst_low && cap_tick && !fifo_in_ready;
    wire underflow = buf_active && !phase_rst_low && primed_r && char_tick && !fifo_out_valid;

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            prst_cnt_r <= 2'h0;
            primed_r <= 1'b0;
            fault_r <= 1'b0;
            buffer_ready_r <= 1'b0;
        end
        else
        begin
            if (ref_rise)
            begin
                prst_cnt_r <= phase_rst_low && prst_cnt_r != stx_pkg::PHASE_RST_EDGES
                    ? prst_cnt_r + 2'h1 : (phase_rst_low ? prst_cnt_r : 2'h0);
            end
            primed_r <= !recenter && (primed_r || pop);
            fault_r <= overflow || underflow || (fault_r && !recenter && !sync_sent);
            buffer_ready_r <= fifo_in_ready;
        end
    end

    // ------------------------------------------------------------
    // Self-test pass counter and progress pulse.
    // ------------------------------------------------------------
    stx_pkg::stx_bist_e bist_st_r;
    logic [8:0] bist_cnt_r;
    logic [4:0] pulse_r;
    wire add_sync = rx_sel == stx_pkg::LVL_LOW && !mode_ll;
    wire short_pulse = rx_sel == stx_pkg::LVL_MID || mode_ll;
    wire [4:0] pulse_len = short_pulse ? stx_pkg::PULSE_SHORT : stx_pkg::PULSE_LONG;
    wire pat_end = bist_st_r == stx_pkg::ST_PATTERN && bist_cnt_r == stx_pkg::BIST_PASS_LAST;
    wire seq_end = bist_st_r == stx_pkg::ST_SYNC && bist_cnt_r == stx_pkg::SYNC_SEQ_LAST;
    wire pass_done = char_tick && ((pat_end && !add_sync) || seq_end);
    wire [4:0] pulse_nxt = pass_done ? pulse_len : (pulse_r != 5'h00 ? pulse_r - 5'h01 : 5'h00);

    always_ff @(posedge sys_clk)
    begin
        if (reset || !bist_on)
        begin
            bist_st_r <= stx_pkg::ST_OFF;
            bist_cnt_r <= 9'h000;
            pulse_r <= 5'h00;
        end
        else if (char_tick)
        begin
            pulse_r <= pulse_nxt;
            bist_cnt_r <= (pat_end || seq_end) ? 9'h000 : bist_cnt_r + 9'h001;
            case (bist_st_r)
                stx_pkg::ST_OFF: bist_st_r <= stx_pkg::ST_PATTERN;
                stx_pkg::ST_PATTERN: bist_st_r <= pat_end && add_sync
                    ? stx_pkg::ST_SYNC : stx_pkg::ST_PATTERN;
                stx_pkg::ST_SYNC: bist_st_r <= seq_end ? stx_pkg::ST_PATTERN : stx_pkg::ST_SYNC;
                default: bist_st_r <= stx_pkg::ST_OFF;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Fault flag, moved only on reference character ticks.
    // ------------------------------------------------------------
    wire flag_nxt = bist_on ? pulse_nxt != 5'h00 : (pop && par_bad) || fault_r;

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            tx_fault_flag_r <= 1'b0;
        end
        else if (char_tick)
        begin
            tx_fault_flag_r <= flag_nxt;
        end
    end

    // ------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    parity_flag_a: assert property (pop && par_bad && !bist_on |=> tx_fault_flag_r)
        else $error("Parity error did not raise the fault flag.");
    bad_char_a: assert property (pop && par_bad |=> enc_char_r == stx_pkg::CHAR_C07)
        else $error("Failing character was not replaced.");
    pass_len_a: assert property (bist_st_r == stx_pkg::ST_SYNC |-> add_sync && bist_cnt_r < 9'h010)
        else $error("Sync sequence out of its 16-tick slot.");
    pulse_len_a: assert property (pass_done |=> pulse_r == (short_pulse ? 5'h01 : 5'h11))
        else $error("Pass pulse length is wrong.");
    ll_sync_a: assert property (mode_ll && bist_on |-> bist_st_r != stx_pkg::ST_SYNC)
        else $error("Sync sequence sent in mode LL.");
    fault_hold_a: assert property (fault_r && !recenter && !sync_sent |=> fault_r)
        else $error("Buffer fault dropped without a clearing event.");
    ref_timed_a: assert property (!char_tick |=> $stable(tx_fault_flag_r))
        else $error("Fault flag moved off a reference tick.");
    cap_clock_a: assert property (cap_tick && !sel_low |-> host_rise && !char_tick || host_rise)
        else $error("Capture used the wrong clock.");
    enc_mode_a: assert property (pop |=> enc_strobe_r && enc_bypass_r == !enc_on)
        else $error("Encoder bypass does not follow mode bit one.");
endmodule

// File: hdl/stx_pkg.sv
/*
 * Shared constants for the transmit input stage: select levels, word layout,
 * substitution character, self-test timing and character kinds.
 * Assumes three-level selects arrive encoded as two bits each.
 */
package stx_pkg;
    // ------------------------------------------------------------
    // Three-level select encoding.
    // ------------------------------------------------------------
    localparam logic [1:0] LVL_LOW = 2'h0;
    localparam logic [1:0] LVL_MID = 2'h1;
    localparam logic [1:0] LVL_HIGH = 2'h2;

    // ------------------------------------------------------------
    // Buffered word layout: special select, odd parity, code, char.
    // ------------------------------------------------------------
    localparam int CHAR_W = 8;
    localparam int CODE_LSB = 8;
    localparam int PAR_BIT = 10;
    localparam int SPC_BIT = 11;
    localparam int WORD_W = 12;
    localparam int FIFO_DEPTH = 4;
    localparam int SYNC_STAGES = 3;

    // ------------------------------------------------------------
    // Character handling and self-test timing in character ticks.
    // ------------------------------------------------------------
    localparam logic [7:0] CHAR_C07 = 8'hE0;
    localparam logic [8:0] BIST_PASS_LAST = 9'h1FE;
    localparam logic [8:0] SYNC_SEQ_LAST = 9'h00F;
    localparam logic [4:0] PULSE_SHORT = 5'h01;
    localparam logic [4:0] PULSE_LONG = 5'h11;
    localparam logic [1:0] PHASE_RST_EDGES = 2'h2;

    // ------------------------------------------------------------
    // Character kinds handed to the encoder.
    // ------------------------------------------------------------
    localparam logic [1:0] KIND_DATA = 2'h0;
    localparam logic [1:0] KIND_SPECIAL = 2'h1;
    localparam logic [1:0] KIND_FILL = 2'h2;
    localparam logic [1:0] KIND_SYNC = 2'h3;

    typedef enum logic [1:0] {ST_OFF, ST_PATTERN, ST_SYNC} stx_bist_e;
endpackage

// File: testbench/stx_host_model.sv
/*
 * Host-side model of the parallel transmit interface: presents character,
 * control code, odd parity and special select, and makes the host transmit
 * clock only while it sends.
 * Assumes the bench runs the reference clock freely and picks the clocking.
 */
`timescale 1ns/1ps

// ------------------------------------------------------------
// Host model.
// ------------------------------------------------------------
module stx_host_model (
    // Reference clock and clocking choice.
    input wire logic reference_clock,
    input wire logic host_mode,
    // Host pins.
    output logic host_tx_clock,
    output logic [7:0] tx_char,
    output logic [1:0] tx_control_code,
    output logic tx_odd_parity_in,
    output logic special_char_select
);
    // Puts one whole word on the lines.
    task automatic put(input logic [7:0] ch, input logic [1:0] cd, input logic par,
                       input logic spc);
        tx_char <= ch;
        tx_control_code <= cd;
        tx_odd_parity_in <= par;
        special_char_select <= spc;
    endtask

    // Idle word: a data character with correct odd parity under both coverages.
    initial
    begin
        host_tx_clock = 1'b0;
        put(8'h1C, 2'h0, 1'b0, 1'b0);
    end

    // Data change at the reference fall and the host clock rises just after the
    // reference rise, so the word is steady well around either capture edge.
    task automatic send(input logic [7:0] ch, input logic [1:0] cd, input logic par,
                        input logic spc);
        @(negedge reference_clock);
        host_tx_clock <= 1'b0;
        put(ch, cd, par, spc);
        @(posedge reference_clock);
        #20;
        host_tx_clock <= host_mode;
    endtask

    // Ends a frame. With host clocking the lines are let go: the clock stands,
    // pulled pins go to their pull levels and the rest invert, so a stale word
    // cannot pass for a fresh one. Reference capture keeps sending idle words.
    task automatic idle();
        @(negedge reference_clock);
        host_tx_clock <= 1'b0;
        if (host_mode)
            put(~tx_char, ~tx_control_code, 1'b1, 1'b0);
        else
            put(8'h1C, 2'h0, 1'b0, 1'b0);
    endtask

    // Words at twice the character rate, to overrun the phase-align buffer.
    task automatic burst(input int n);
        repeat (n)
        begin
            host_tx_clock <= 1'b0;
            put(tx_char + 8'h01, 2'h0, ~^(tx_char + 8'h01), 1'b0);
            #50;
            host_tx_clock <= 1'b1;
            #50;
        end
        host_tx_clock <= 1'b0;
    endtask
endmodule

// File: testbench/testbench.sv
/*
 * Self-checking bench for the transmit input stage: parity and substitution,
 * encoder kinds, host clocking, buffer faults and self-test progress.
 * Assumes the host model beside it and the design's own assertions.
 */
`timescale 1ns/1ps

module testbench;
    localparam logic [3:0] MODE_ENC = {stx_pkg::LVL_MID, stx_pkg::LVL_LOW};
    logic sys_clk, reset, reference_clock, tx_phase_reset_n, ref_half_rate_select, bist_enable;
    logic [1:0] tx_input_clock_select, rx_output_clock_select, parity_control;
    logic [3:0] tx_mode_select;
    logic host_tx_clock, tx_odd_parity_in, special_char_select;
    logic [7:0] tx_char, enc_char_r;
    logic [1:0] tx_control_code, enc_code_r, enc_kind_r;
    logic enc_strobe_r, enc_bypass_r, tx_fault_flag_r, buffer_ready_r;
    logic [1:0] kinds [4] = '{stx_pkg::KIND_DATA, stx_pkg::KIND_SPECIAL, stx_pkg::KIND_FILL,
                              stx_pkg::KIND_SYNC};
    int error_cnt = 0;
    int comparisons = 0;

    // ------------------------------------------------------------
    // Clocks: the reference is offset so its edges never meet sys_clk.
    // ------------------------------------------------------------
    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    initial
    begin
        reference_clock = 1'b0;
        #7;
        forever #100 reference_clock = ~reference_clock;
    end

    stx_input_stage u_dut (
        .sys_clk(sys_clk), .reset(reset), .reference_clock(reference_clock),
        .host_tx_clock(host_tx_clock), .tx_phase_reset_n(tx_phase_reset_n),
        .tx_input_clock_select(tx_input_clock_select),
        .ref_half_rate_select(ref_half_rate_select),
        .rx_output_clock_select(rx_output_clock_select), .tx_mode_select(tx_mode_select),
        .parity_control(parity_control), .bist_enable(bist_enable), .tx_char(tx_char),
        .tx_control_code(tx_control_code), .tx_odd_parity_in(tx_odd_parity_in),
        .special_char_select(special_char_select), .enc_strobe_r(enc_strobe_r),
        .enc_char_r(enc_char_r), .enc_code_r(enc_code_r), .enc_kind_r(enc_kind_r),
        .enc_bypass_r(enc_bypass_r), .tx_fault_flag_r(tx_fault_flag_r),
        .buffer_ready_r(buffer_ready_r)
    );

    stx_host_model u_host (
        .reference_clock(reference_clock),
        .host_mode(tx_input_clock_select !== stx_pkg::LVL_LOW),
        .host_tx_clock(host_tx_clock), .tx_char(tx_char), .tx_control_code(tx_control_code),
        .tx_odd_parity_in(tx_odd_parity_in), .special_char_select(special_char_select)
    );

    // ------------------------------------------------------------
    // Shared tasks.
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic test_done();
        $display("Mismatches %0d, comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Static pins other than bist_enable only change under reset, so every setup starts clean.
    task automatic cfg(input logic [1:0] tsel, input logic half, input logic [1:0] rx,
                       input logic [3:0] mode, input logic [1:0] par, input logic bist);
        @(negedge sys_clk);
        reset = 1'b1;
        bist_enable = 1'b0;
        tx_input_clock_select = tsel;
        ref_half_rate_select = half;
        rx_output_clock_select = rx;
        tx_mode_select = mode;
        parity_control = par;
        u_host.idle();
        repeat (8) @(negedge sys_clk);
        check({enc_strobe_r, enc_char_r, enc_code_r, enc_kind_r, tx_fault_flag_r}, 16'h0, "rst");
        reset = 1'b0;
        repeat (4) @(negedge sys_clk);
        bist_enable = bist;
    endtask

    // Waits for the next non-idle character and compares all encoder outputs.
    task automatic expect_char(input logic [12:0] e);
        int n = 0;
        while (!(enc_strobe_r === 1'b1 && enc_char_r !== 8'h1C) && n < 400)
        begin
            @(negedge sys_clk);
            n++;
        end
        check({enc_strobe_r, enc_char_r, enc_code_r, enc_kind_r, enc_bypass_r},
              {1'b1, e}, "char");
        @(negedge sys_clk);
    endtask

    // One word {spc, par, code, char} alone in the idle stream, then the flag.
    task automatic one_char(input logic [11:0] w, input logic [12:0] e, input logic flag);
        fork
            begin
                u_host.send(w[7:0], w[9:8], w[10], w[11]);
                u_host.idle();
            end
            expect_char(e);
        join
        repeat (2) @(negedge sys_clk);
        check(tx_fault_flag_r, flag, "flag");
        repeat (12) @(negedge sys_clk);
        check(tx_fault_flag_r, 1'b0, "flag end");
    endtask

    // Phase reset held low over three reference rises.
    task automatic recenter();
        @(negedge reference_clock);
        @(negedge sys_clk);
        tx_phase_reset_n = 1'b0;
        repeat (3) @(posedge reference_clock);
        @(negedge sys_clk);
        tx_phase_reset_n = 1'b1;
        repeat (20) @(negedge sys_clk);
    endtask

    task automatic wait_flag(input logic lvl, output int n);
        n = 0;
        while (tx_fault_flag_r !== lvl && n < 6000)
        begin
            @(negedge sys_clk);
            n++;
        end
    endtask

    // Measures one self-test pulse and the pass length, in ticks of 8 or 4 cycles.
    task automatic bist_case(input logic [1:0] rx, input logic [3:0] mode, input logic half,
                             input int hi, input int per);
        int t = half ? 4 : 8;
        int n;
        int h;
        cfg(stx_pkg::LVL_LOW, half, rx, mode, stx_pkg::LVL_LOW, 1'b1);
        wait_flag(1'b1, n);
        wait_flag(1'b0, h);
        wait_flag(1'b1, n);
        check({15'h0, h >= hi * t - 2 && h <= hi * t + 2}, 16'h1, "bist pulse");
        n = n + h;
        check({15'h0, n >= per * t - 2 && n <= per * t + 2}, 16'h1, "bist pass");
    endtask

    // ------------------------------------------------------------
    // Watchdog: the whole sequence needs well under 2 ms.
    // ------------------------------------------------------------
    initial
    begin
        #2000000;
        error_cnt++;
        $display("[ERR] %0t watchdog expired", $time);
        test_done();
    end

    // ------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------
    initial
    begin
        reset = 1'b1;
        tx_phase_reset_n = 1'b1;
        bist_enable = 1'b0;
        ref_half_rate_select = 1'b0;
        tx_input_clock_select = stx_pkg::LVL_LOW;
        rx_output_clock_select = stx_pkg::LVL_MID;
        tx_mode_select = MODE_ENC;
        parity_control = stx_pkg::LVL_MID;
        // Reference capture, encoder on, parity over the character only.
        cfg(stx_pkg::LVL_LOW, 1'b0, stx_pkg::LVL_MID, MODE_ENC, stx_pkg::LVL_MID, 1'b0);
        for (int c = 0; c < 4; c++)
            one_char({2'h1, 2'(c), 8'hA5}, {8'hA5, 2'(c), kinds[c], 1'b0}, 1'b0);
        one_char(12'hCA5, {8'hA5, 2'h0, stx_pkg::KIND_SPECIAL, 1'b0}, 1'b0);
        one_char(12'h3A5, {stx_pkg::CHAR_C07, 2'h0, stx_pkg::KIND_DATA, 1'b0}, 1'b1);
        // Parity over character and code, then parity off.
        cfg(stx_pkg::LVL_LOW, 1'b0, stx_pkg::LVL_MID, MODE_ENC, stx_pkg::LVL_HIGH, 1'b0);
        one_char(12'h5A5, {stx_pkg::CHAR_C07, 2'h0, stx_pkg::KIND_DATA, 1'b0}, 1'b1);
        one_char(12'h1A5, {8'hA5, 2'h1, stx_pkg::KIND_SPECIAL, 1'b0}, 1'b0);
        cfg(stx_pkg::LVL_LOW, 1'b0, stx_pkg::LVL_MID, MODE_ENC, stx_pkg::LVL_LOW, 1'b0);
        one_char(12'h0A5, {8'hA5, 2'h0, stx_pkg::KIND_DATA, 1'b0}, 1'b0);
        // Encoder bypassed: code bits are data, bad characters still replaced.
        cfg(stx_pkg::LVL_LOW, 1'b0, stx_pkg::LVL_MID, 4'h0, stx_pkg::LVL_MID, 1'b0);
        one_char(12'h7A5, {8'hA5, 2'h3, stx_pkg::KIND_DATA, 1'b1}, 1'b0);
        one_char(12'h3A5, {stx_pkg::CHAR_C07, 2'h0, stx_pkg::KIND_DATA, 1'b1}, 1'b1);
        // Host clocking, MID then HIGH: frame, underflow, overflow, recentering.
        for (int s = 1; s < 3; s++)
        begin
            cfg(2'(s), 1'b0, stx_pkg::LVL_MID, MODE_ENC, stx_pkg::LVL_MID, 1'b0);
            recenter();
            fork
                begin
                    u_host.send(8'h11, 2'h0, 1'b1, 1'b0);
                    u_host.send(8'h22, 2'h0, 1'b1, 1'b0);
                    u_host.send(8'h37, 2'h1, 1'b0, 1'b0);
                    u_host.idle();
                end
                begin
                    expect_char({8'h11, 2'h0, stx_pkg::KIND_DATA, 1'b0});
                    expect_char({8'h22, 2'h0, stx_pkg::KIND_DATA, 1'b0});
                    expect_char({8'h37, 2'h1, stx_pkg::KIND_SPECIAL, 1'b0});
                end
            join
            repeat (60) @(negedge sys_clk);
            check(tx_fault_flag_r, 1'b1, "underflow");
            repeat (80) @(negedge sys_clk);
            check(tx_fault_flag_r, 1'b1, "sticky");
            recenter();
            check(tx_fault_flag_r, 1'b0, "recentred");
            fork
                u_host.burst(16);
                begin
                    wait_flag(1'b1, s);
                    while (buffer_ready_r !== 1'b0 && s < 200)
                    begin
                        @(negedge sys_clk);
                        s++;
                    end
                    check(buffer_ready_r, 1'b0, "full");
                end
            join
            check(tx_fault_flag_r, 1'b1, "overflow");
            s = int'(tx_input_clock_select);
            recenter();
            check({tx_fault_flag_r, buffer_ready_r}, 2'h1, "flushed");
        end
        // Self-test progress on the flag.
        bist_case(stx_pkg::LVL_MID, MODE_ENC, 1'b0, 1, 511);
        bist_case(stx_pkg::LVL_HIGH, MODE_ENC, 1'b0, 17, 511);
        bist_case(stx_pkg::LVL_LOW, MODE_ENC, 1'b0, 17, 527);
        bist_case(stx_pkg::LVL_LOW, 4'h0, 1'b0, 1, 511);
        bist_case(stx_pkg::LVL_MID, MODE_ENC, 1'b1, 1, 511);
        test_done();
    end
endmodule
